// >>> src/timer_pkg.sv
`default_nettype none
package timer_pkg;
    // Width of the channel counter and its extremes.
    localparam int          CNT_W        = 16;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hffff;

    // Count profiles.
    localparam logic [1:0] PROF_UP_MAX   = 2'h0;
    localparam logic [1:0] PROF_UPDN_MAX = 2'h1;
    localparam logic [1:0] PROF_UP_CMPC  = 2'h2;
    localparam logic [1:0] PROF_UPDN_CMPC = 2'h3;

    // Edge selection codes shared by trigger and event edge fields.
    localparam logic [1:0] EDGE_NONE     = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    // Output action codes.
    localparam logic [1:0] ACT_NONE      = 2'h0;
    localparam logic [1:0] ACT_SET       = 2'h1;
    localparam logic [1:0] ACT_CLEAR     = 2'h2;
    localparam logic [1:0] ACT_TOGGLE    = 2'h3;

    // Event source code that takes the second line as input.
    localparam logic [1:0] EVT_SRC_LINE_B = 2'h0;

    // Count clock selection: five internal rates, then external clocks 0 to 2.
    localparam logic [2:0] CLK_SEL_EXT0  = 3'h5;
    localparam logic [2:0] CLK_SEL_EXT1  = 3'h6;
    localparam logic [2:0] CLK_SEL_EXT2  = 3'h7;
    localparam int          PRESC_W      = 10;
    localparam int          DIV0_LOG2    = 1;
    localparam int          DIV1_LOG2    = 3;
    localparam int          DIV2_LOG2    = 5;
    localparam int          DIV3_LOG2    = 7;
    localparam int          DIV4_LOG2    = 10;

    // Positions of the synchronised pins in the pin vector.
    localparam int PIN_XC0 = 0;
    localparam int PIN_XC1 = 1;
    localparam int PIN_XC2 = 2;
    localparam int PIN_LA  = 3;
    localparam int PIN_LB  = 4;
    localparam int PIN_PHA = 5;
    localparam int PIN_PHB = 6;
    localparam int PIN_IDX = 7;
    localparam int PIN_CHN = 8;
    localparam int NUM_PINS = 9;

    // Channel mode configuration, held static by software while counting.
    typedef struct packed {
        logic       wave_mode;
        logic [2:0] count_clock_sel;
        logic       capture_trig_line_sel;
        logic [1:0] capture_trig_edge;
        logic       cmp_c_trig_en;
        logic [1:0] ext_event_source;
        logic [1:0] ext_event_edge;
        logic       ext_event_trig_en;
        logic [1:0] count_profile_sel;
        logic       stop_on_cmp_c;
        logic       disable_on_cmp_c;
        logic [1:0] a_on_cmp_a;
        logic [1:0] a_on_cmp_c;
        logic [1:0] a_on_evt;
        logic [1:0] a_on_sw;
        logic [1:0] b_on_cmp_b;
        logic [1:0] b_on_cmp_c;
        logic [1:0] b_on_evt;
        logic [1:0] b_on_sw;
    } mode_cfg_t;

    // Compare values.
    typedef struct packed {
        logic [15:0] compare_a;
        logic [15:0] compare_b;
        logic [15:0] compare_c_value;
    } compare_set_t;
endpackage : timer_pkg
`default_nettype wire

// >>> src/pin_sync_edge.sv
`default_nettype none
module pin_sync_edge (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two flops shield the logic from pin metastability; only the second is read.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge pulses last one cycle and lag the pin by about two cycles.
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule : pin_sync_edge
`default_nettype wire

// >>> src/timer_waveform_quad_decoder.sv
// Function
// - Select bit picks line A or B for capture trigger
// - Edge field picks rising/falling/both; zero disables
// - Mode bit set means waveform, clear means capture
// - Waveform gives PWM pairs or single/repeat pulses
// - Line A output; line B output unless event source
// - Compares A, B, C usable in every profile
// - Profile 00 counts up to FFFF, wraps
// - Up profiles: triggers reset counter any time
// - Profiles 00 and 01: compare C never triggers
// - Profile 10 counts to compare C, resets
// - Profile 01 counts up FFFF then down
// - Profile 11 counts up to C then down
// - Up-down profiles: trigger reverses count direction
// - Compare C stops or disables count clock
// - Event source and edge select; edge zero means none
// - Line B as source: no drive, compare B idle
// - Event triggers only when trigger enable set
// - Events set, clear or toggle the outputs
// - Decoder off leaves channel an ordinary timer
// - Decoder: phase edges or index pulses counted
// - Decoder on ignores external clock 0 routing
// - Compare C match sets the status flag
// - Trigger starts clock; resets (up) or reverses (up-down) count at next count edge
// - Block sync write triggers like software, no output action
`default_nettype none
module timer_waveform_quad_decoder (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire timer_pkg::mode_cfg_t    channel_mode_cfg,
    input  wire timer_pkg::compare_set_t compares,
    input  wire logic                    quad_decode_en,
    input  wire logic                    quad_chan_sel,
    input  wire logic                    ext_clk0_routing,
    input  wire logic                    clk_enable_cmd,
    input  wire logic                    clk_disable_cmd,
    input  wire logic                    sw_trigger,
    input  wire logic                    block_sync_write,
    input  wire logic                    status_read,
    input  wire logic                    ext_clock_in0,
    input  wire logic                    ext_clock_in1,
    input  wire logic                    ext_clock_in2,
    input  wire logic                    chain_clock_in,
    input  wire logic                    phase_a_input,
    input  wire logic                    phase_b_input,
    input  wire logic                    index_input,
    input  wire logic                    chan_line_a_in,
    input  wire logic                    chan_line_b_in,
    output logic                         chan_line_a_out,
    output logic                         chan_line_a_oe,
    output logic                         chan_line_b_out,
    output logic                         chan_line_b_oe,
    output logic [15:0]                  counter_value,
    output logic                         clk_enabled,
    output logic                         clk_running,
    output logic                         counting_up,
    output logic                         cmp_c_status_flag
);
    import timer_pkg::*;

    mode_cfg_t             cfg;
    logic [NUM_PINS-1:0]   pins_raw;
    logic [NUM_PINS-1:0]   pin_lvl;
    logic [NUM_PINS-1:0]   pin_rise;
    logic [NUM_PINS-1:0]   pin_fall;
    logic [PRESC_W-1:0]    presc_q;
    logic [4:0]            int_tick;
    logic                  quad_pulse;
    logic                  ext0_pulse;
    logic                  sel_tick;
    logic                  cnt_tick;
    logic                  cap_trig;
    logic                  ext_evt;
    logic                  sync_trig;
    logic                  trig_now;
    logic                  line_b_is_src;
    logic                  top_hit;
    logic [15:0]           top_val;
    logic                  cmp_a_hit;
    logic                  cmp_b_hit;
    logic                  cmp_c_hit;
    logic                  cmp_c_trig;
    logic                  up_profile;
    logic                  trig_pend_q;
    logic                  en_q;
    logic                  run_q;
    logic                  dir_up_q;
    logic [15:0]           cnt_q;
    logic [15:0]           cnt_d;
    logic                  dir_up_d;
    logic                  flag_q;
    logic                  a_q;
    logic                  b_q;

    assign cfg = channel_mode_cfg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Every pin crosses from outside through its own synchroniser.
    assign pins_raw = {chain_clock_in, index_input, phase_b_input, phase_a_input,
                       chan_line_b_in, chan_line_a_in, ext_clock_in2, ext_clock_in1,
                       ext_clock_in0};
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        pin_sync_edge u_sync (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .pin_in  (pins_raw[i]),
            .level   (pin_lvl[i]),
            .rise    (pin_rise[i]),
            .fall    (pin_fall[i])
        );
    end

    // Picks the edge pulse of a synchronised pin according to an edge code.
    function automatic logic edge_of(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            EDGE_RISE: edge_of = r;
            EDGE_FALL: edge_of = f;
            EDGE_BOTH: edge_of = r | f;
            default:   edge_of = 1'b0;
        endcase
    endfunction : edge_of

    // Applies one output action to a line level.
    function automatic logic act_on(input logic [1:0] act, input logic hit, input logic cur);
        if (!hit) begin
            act_on = cur;
        end else begin
            case (act)
                ACT_SET:    act_on = 1'b1;
                ACT_CLEAR:  act_on = 1'b0;
                ACT_TOGGLE: act_on = ~cur;
                default:    act_on = cur;
            endcase
        end
    endfunction : act_on

    // Free-running prescaler; each internal rate is a one-cycle enable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end
    assign int_tick[0] = &presc_q[DIV0_LOG2-1:0];
    assign int_tick[1] = &presc_q[DIV1_LOG2-1:0];
    assign int_tick[2] = &presc_q[DIV2_LOG2-1:0];
    assign int_tick[3] = &presc_q[DIV3_LOG2-1:0];
    assign int_tick[4] = &presc_q[DIV4_LOG2-1:0];

    // The decoder replaces external clock 0 and overrides its routing field.
    assign quad_pulse = quad_chan_sel ? pin_rise[PIN_IDX]
                      : (pin_rise[PIN_PHA] | pin_fall[PIN_PHA] |
                         pin_rise[PIN_PHB] | pin_fall[PIN_PHB]);
    assign ext0_pulse = quad_decode_en ? quad_pulse
                      : (ext_clk0_routing ? pin_rise[PIN_CHN] : pin_rise[PIN_XC0]);

    quad_route_a: assert property (quad_decode_en |-> ext0_pulse == quad_pulse)
        else $error("decoder enabled but external clock 0 not taken from decoder");

    // Count clock selection; external clocks count on their rising edge.
    always_comb begin
        case (cfg.count_clock_sel)
            CLK_SEL_EXT0: sel_tick = ext0_pulse;
            CLK_SEL_EXT1: sel_tick = pin_rise[PIN_XC1];
            CLK_SEL_EXT2: sel_tick = pin_rise[PIN_XC2];
            default:      sel_tick = int_tick[cfg.count_clock_sel];
        endcase
    end
    assign cnt_tick = sel_tick & en_q & run_q;

    // Capture trigger line and edge; edge code zero gives no trigger at all.
    assign cap_trig = ~cfg.wave_mode &
        (cfg.capture_trig_line_sel
            ? edge_of(cfg.capture_trig_edge, pin_rise[PIN_LB], pin_fall[PIN_LB])
            : edge_of(cfg.capture_trig_edge, pin_rise[PIN_LA], pin_fall[PIN_LA]));

    cap_none_a: assert property (cfg.capture_trig_edge == EDGE_NONE |-> !cap_trig)
        else $error("capture trigger fired with its edge field cleared");

    // Waveform external event from line B or one of the three clock pins.
    always_comb begin
        case (cfg.ext_event_source)
            EVT_SRC_LINE_B: ext_evt = edge_of(cfg.ext_event_edge, pin_rise[PIN_LB],
                                              pin_fall[PIN_LB]);
            2'h1:           ext_evt = edge_of(cfg.ext_event_edge, pin_rise[PIN_XC0],
                                              pin_fall[PIN_XC0]);
            2'h2:           ext_evt = edge_of(cfg.ext_event_edge, pin_rise[PIN_XC1],
                                              pin_fall[PIN_XC1]);
            default:        ext_evt = edge_of(cfg.ext_event_edge, pin_rise[PIN_XC2],
                                              pin_fall[PIN_XC2]);
        endcase
        ext_evt = ext_evt & cfg.wave_mode;
    end
    assign line_b_is_src = cfg.wave_mode & (cfg.ext_event_source == EVT_SRC_LINE_B);

    // Trigger sources other than compare C; a block sync write counts like a software trigger.
    assign sync_trig = sw_trigger | block_sync_write;
    assign trig_now  = sync_trig | cap_trig |
                       (ext_evt & cfg.ext_event_trig_en);

    // Compare matches are judged at the count edge on the value being left.
    assign up_profile = ~cfg.wave_mode | ~cfg.count_profile_sel[0];
    assign top_val = cfg.count_profile_sel[1] ? compares.compare_c_value : CNT_MAX;
    assign top_hit = cnt_q == top_val;
    assign cmp_a_hit = cnt_tick & (cnt_q == compares.compare_a);
    assign cmp_b_hit = cnt_tick & (cnt_q == compares.compare_b) & ~line_b_is_src;
    assign cmp_c_hit = cnt_tick & (cnt_q == compares.compare_c_value);
    // In waveform mode only profile 10 lets compare C reset the count, 00 and 01 never do; in capture mode cmp_c_trig_en decides.
    assign cmp_c_trig = cmp_c_hit & (cfg.wave_mode
                        ? (cfg.count_profile_sel == PROF_UP_CMPC) : cfg.cmp_c_trig_en);

    // Triggers wait here until the selected clock's next active edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_pend_q <= 1'b0;
        end else if (trig_now) begin
            trig_pend_q <= 1'b1;
        end else if (cnt_tick) begin
            trig_pend_q <= 1'b0;
        end
    end

    // Enable and run state; a trigger restarts a running stop but never a disable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q  <= 1'b0;
            run_q <= 1'b0;
        end else if (clk_disable_cmd) begin
            en_q  <= 1'b0;
            run_q <= 1'b0;
        end else if (cmp_c_hit & cfg.disable_on_cmp_c & cfg.wave_mode) begin
            en_q  <= 1'b0;
            run_q <= 1'b0;
        end else begin
            if (clk_enable_cmd) begin
                en_q <= 1'b1;
            end
            if (trig_now & (en_q | clk_enable_cmd)) begin
                run_q <= 1'b1;
            end else if (cmp_c_hit & cfg.stop_on_cmp_c & cfg.wave_mode) begin
                run_q <= 1'b0;
            end else if (clk_enable_cmd & ~en_q) begin
                run_q <= 1'b1;
            end
        end
    end

    stop_cmp_a: assert property (cmp_c_hit && cfg.wave_mode && cfg.stop_on_cmp_c
                                 && !trig_now |=> !run_q)
        else $error("compare C match did not stop the count clock");
    dis_cmp_a: assert property (cmp_c_hit && cfg.wave_mode && cfg.disable_on_cmp_c
                                |=> !en_q && !run_q)
        else $error("compare C match did not disable the count clock");
    sync_start_a: assert property (block_sync_write && en_q && !clk_disable_cmd
                                   && !(cmp_c_hit && cfg.disable_on_cmp_c && cfg.wave_mode)
                                   |=> run_q && trig_pend_q)
        else $error("sync write did not start the channel like a trigger");

    // Next count and direction for each profile.
    always_comb begin
        cnt_d    = cnt_q;
        dir_up_d = dir_up_q;
        if (trig_pend_q && up_profile) begin
            cnt_d    = CNT_ZERO;
            dir_up_d = 1'b1;
        end else if (trig_pend_q) begin
            dir_up_d = ~dir_up_q;
            cnt_d    = dir_up_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end else if (cmp_c_trig) begin
            cnt_d = CNT_ZERO;
        end else if (up_profile) begin
            cnt_d = cnt_q + 16'h0001;
        end else if (dir_up_q && top_hit) begin
            dir_up_d = 1'b0;
            cnt_d    = cnt_q - 16'h0001;
        end else if (!dir_up_q && cnt_q == CNT_ZERO) begin
            dir_up_d = 1'b1;
            cnt_d    = cnt_q + 16'h0001;
        end else begin
            cnt_d = dir_up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        end
    end

    // The counter only moves on an enabled, running count edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= CNT_ZERO;
            dir_up_q <= 1'b1;
        end else if (cnt_tick) begin
            cnt_q    <= cnt_d;
            dir_up_q <= dir_up_d;
        end
    end

    wrap_max_a: assert property (cnt_tick && cfg.wave_mode && !trig_pend_q
        && cfg.count_profile_sel == PROF_UP_MAX && cnt_q == CNT_MAX
        |=> cnt_q == CNT_ZERO)
        else $error("profile 00 did not wrap from FFFF to zero");
    reset_c_a: assert property (cnt_tick && cfg.wave_mode && !trig_pend_q
        && cfg.count_profile_sel == PROF_UP_CMPC && cnt_q == compares.compare_c_value
        |=> cnt_q == CNT_ZERO)
        else $error("profile 10 did not reset on compare C");
    turn_top_a: assert property (cnt_tick && cfg.wave_mode && !trig_pend_q && dir_up_q
        && cfg.count_profile_sel[0] && top_hit
        |=> !dir_up_q && cnt_q == $past(cnt_q) - 16'h0001)
        else $error("up-down profile did not turn at its top");
    trig_zero_a: assert property (cnt_tick && trig_pend_q && up_profile
        |=> cnt_q == CNT_ZERO)
        else $error("trigger did not zero the counter at the count edge");
    trig_flip_a: assert property (cnt_tick && trig_pend_q && !up_profile
        |=> dir_up_q != $past(dir_up_q))
        else $error("trigger did not reverse the up-down direction");

    // Status flag is sticky; a match in the clearing cycle wins over the read.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (cmp_c_hit) begin
            flag_q <= 1'b1;
        end else if (status_read) begin
            flag_q <= 1'b0;
        end
    end

    flag_set_a: assert property (cmp_c_hit |=> flag_q)
        else $error("compare C match did not set the status flag");

    // Output controller; software trigger has top priority, compare A/B lowest.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else if (cfg.wave_mode) begin
            a_q <= act_on(cfg.a_on_sw, sw_trigger,
                   act_on(cfg.a_on_evt, ext_evt,
                   act_on(cfg.a_on_cmp_c, cmp_c_hit,
                   act_on(cfg.a_on_cmp_a, cmp_a_hit, a_q))));
            if (!line_b_is_src) begin
                b_q <= act_on(cfg.b_on_sw, sw_trigger,
                       act_on(cfg.b_on_evt, ext_evt,
                       act_on(cfg.b_on_cmp_c, cmp_c_hit,
                       act_on(cfg.b_on_cmp_b, cmp_b_hit, b_q))));
            end
        end
    end

    // Drive enables follow the mode; line B is released when it is the event source.
    assign chan_line_a_oe  = cfg.wave_mode;
    assign chan_line_b_oe  = cfg.wave_mode & ~line_b_is_src;
    assign chan_line_a_out = a_q;
    assign chan_line_b_out = b_q;
    assign counter_value     = cnt_q;
    assign clk_enabled       = en_q;
    assign clk_running       = run_q;
    assign counting_up       = dir_up_q;
    assign cmp_c_status_flag = flag_q;

    line_b_src_a: assert property (line_b_is_src |-> !chan_line_b_oe ##1 $stable(b_q))
        else $error("line B driven or changed while it is the event source");
    line_a_oe_a: assert property (cfg.wave_mode |-> chan_line_a_oe)
        else $error("line A not driven in waveform operation");

    cov_wrap_c: cover property (cnt_tick && cnt_q == CNT_MAX && cfg.wave_mode);
    cov_updn_c: cover property (cnt_tick && trig_pend_q && !up_profile);
    cov_quad_c: cover property (quad_decode_en && cnt_tick);
    cov_stop_c: cover property (cmp_c_hit && cfg.stop_on_cmp_c ##1 !run_q);
endmodule : timer_waveform_quad_decoder
`default_nettype wire

// >>> test/ext_signal_model.sv
`default_nettype none
module ext_signal_model (
    output logic ext_clk0,
    output logic line_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slow external clock, so the two-flop synchronisers see every level.
    initial begin
        ext_clk0 = 1'b0;
        forever #40 ext_clk0 = ~ext_clk0;
    end
    // Event line on line B; driven at all times, so it never floats.
    initial begin
        line_b = 1'b0;
        forever #370 line_b = ~line_b;
    end
endmodule : ext_signal_model
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_pkg::*;
    logic ref_clk, rst_n, en_cmd, sw_trig, sync_wr, xc0, lb, a_o, a_oe, b_o, b_oe, en, run, up, flag;
    logic [6:0]   noise;
    logic [15:0]  cv;
    mode_cfg_t    cfg;
    compare_set_t cmps;
    int seed = 32'h6afe56e4;
    int errors = 0;
    int cmp_count = 0;
    ext_signal_model SRC (.ext_clk0(xc0), .line_b(lb));
    timer_waveform_quad_decoder DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .channel_mode_cfg(cfg), .compares(cmps),
        .quad_decode_en(1'b0), .quad_chan_sel(1'b0), .ext_clk0_routing(1'b0),
        .clk_enable_cmd(en_cmd), .clk_disable_cmd(1'b0), .sw_trigger(sw_trig),
        .block_sync_write(sync_wr), .status_read(1'b0), .ext_clock_in0(xc0),
        .ext_clock_in1(noise[0]), .ext_clock_in2(noise[1]), .chain_clock_in(noise[2]),
        .phase_a_input(noise[3]), .phase_b_input(noise[4]), .index_input(noise[5]),
        .chan_line_a_in(noise[6]), .chan_line_b_in(lb), .chan_line_a_out(a_o),
        .chan_line_a_oe(a_oe), .chan_line_b_out(b_o), .chan_line_b_oe(b_oe),
        .counter_value(cv), .clk_enabled(en), .clk_running(run), .counting_up(up),
        .cmp_c_status_flag(flag));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Random noise on pins that must stay inert while the decoder is off.
    always @(negedge ref_clk) noise <= 7'($random(seed));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // Integer model of the count; it follows itself, never the counter.
    // A software trigger raised in loop cycle trig_at is applied at the next count step.
    task automatic watch(input int n, input int prof, input int trig_at);
        int prev;
        int dn;
        int exp;
        int pend;
        int steps;
        prev = 0;
        dn = 0;
        pend = 0;
        steps = 0;
        for (int k = 0; k < n; k++) begin
            if (k == trig_at) sw_trig = 1'b1;
            else if (k == trig_at + 1) sw_trig = 1'b0;
            @(negedge ref_clk);
            if (cv !== 16'(prev)) begin
                if (prof == 3 && pend != 0) dn = (dn == 0);
                else if (prof == 3 && prev == cmps.compare_c_value) dn = 1;
                else if (prof == 3 && prev == 0) dn = 0;
                if (prof == 2 && (pend != 0 || prev == cmps.compare_c_value)) exp = 0;
                else exp = dn ? prev - 1 : prev + 1;
                check("counter", 16'(exp), cv);
                if (prof == 3) check("direction", 16'(dn == 0), {15'h0000, up});
                prev = exp;
                pend = 0;
                steps++;
            end
            if (k == trig_at) pend = 1;
        end
        check("counter moving", 16'h0001, 16'(steps >= n / 4));
    endtask : watch
    // A trigger from a value away from zero and compare C must zero the counter.
    task automatic pulse(input bit use_sync);
        int i;
        logic [15:0] was;
        for (i = 0; i < 40 && (cv === 16'h0000 || cv === cmps.compare_c_value); i++)
            @(negedge ref_clk);
        if (cv === 16'h0000) check("counter before trigger", 16'h0001, cv);
        if (use_sync) sync_wr = 1'b1;
        else sw_trig = 1'b1;
        @(negedge ref_clk);
        {sw_trig, sync_wr} = 2'b00;
        was = cv;
        for (i = 0; i < 8 && cv === was; i++) @(negedge ref_clk);
        check("counter after trigger", 16'h0000, cv);
    endtask : pulse
    task automatic print_verdict();
        $display("comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        {rst_n, en_cmd, sw_trig, sync_wr} = 4'h0;
        cfg = '0;
        cfg.wave_mode = 1'b1;
        cfg.ext_event_edge = EDGE_RISE;
        cfg.count_profile_sel = PROF_UPDN_CMPC;
        cfg.a_on_sw = ACT_SET;
        cfg.b_on_sw = ACT_SET;
        cmps = '0;
        cmps.compare_c_value = 16'h0008 + 16'($random(seed) & 15);
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        en_cmd = 1'b1;
        @(negedge ref_clk);
        en_cmd = 1'b0;
        check("clock enabled", 16'h0001, {15'h0000, en});
        check("clock running", 16'h0001, {15'h0000, run});
        check("line a oe", 16'h0001, {15'h0000, a_oe});
        check("line b oe", 16'h0000, {15'h0000, b_oe});
        watch(400, 3, 150);
        check("line a level", 16'h0001, {15'h0000, a_o});
        check("line b level", 16'h0000, {15'h0000, b_o});
        cfg.count_profile_sel = PROF_UP_CMPC;
        pulse(1'b0);
        watch(400, 2, -5);
        check("compare c flag", 16'h0001, {15'h0000, flag});
        pulse(1'b1);
        cfg.ext_event_source = 2'h1;
        @(negedge ref_clk);
        check("line b oe", 16'h0001, {15'h0000, b_oe});
        pulse(1'b0);
        check("line b level", 16'h0001, {15'h0000, b_o});
        // Compare C stop must halt the clock; a trigger must start it again.
        cfg.stop_on_cmp_c = 1'b1;
        for (int i = 0; i < 80 && run === 1'b1; i++) @(negedge ref_clk);
        check("clock running after stop", 16'h0000, {15'h0000, run});
        sw_trig = 1'b1;
        @(negedge ref_clk);
        sw_trig = 1'b0;
        check("clock running after trigger", 16'h0001, {15'h0000, run});
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
